// >>> logic/cise_cfg.svh
`ifndef CISE_CFG_SVH
`define CISE_CFG_SVH
// register byte offsets on the bus
`define CISE_OFF_STATUS 8'h00
`define CISE_OFF_PC 8'h04
`define CISE_OFF_PSTAT 8'h08
`define CISE_OFF_RETPC 8'h0c
`define CISE_OFF_SAVST 8'h10
`define CISE_OFF_CAUSE 8'h14
`define CISE_OFF_GRIDX 8'h18
`define CISE_OFF_GRDATA 8'h1c
`define CISE_OFF_INSTR 8'h20
// status word bit positions
`define CISE_FLG_Z 0
`define CISE_FLG_S 1
`define CISE_FLG_OVF 2
`define CISE_FLG_CARRY 3
`define CISE_FLG_IDIS 5
`define CISE_FLG_EXC 6
`define CISE_PC_RST 32'h00000000
`define CISE_PSTAT_RST 32'h00000000
// opcode field, bits 10..5 of the first halfword
`define CISE_OPC_SUB 6'h0d
`define CISE_OPC_RSUB 6'h0c
`define CISE_OPC_ANDT 6'h0b
`define CISE_OPC_XOR 6'h09
`define CISE_OPC_XIMM 6'h35
`define CISE_OPC_BTSTD 6'h3e
`define CISE_OPC_EXT 6'h3f
// bits 15..5 of single register forms
`define CISE_HI_SWITCH 11'h002
`define CISE_HI_ZEXB 11'h004
`define CISE_HI_SEXB 11'h005
`define CISE_HI_ZEXH 11'h006
`define CISE_HI_SEXH 11'h007
`define CISE_BTSTR_HW1 16'h00e6
`define CISE_BTSTD_PRE 2'h3
`define CISE_TRAP_PC_LO 32'h00000040
`define CISE_TRAP_PC_HI 32'h00000050
`define CISE_TRAP_CODE 16'h0040
// execution cycle counts, memory step index and instruction byte lengths
`define CISE_CYC_ONE 3'd1
`define CISE_CYC_SWITCH 3'd5
`define CISE_CYC_TRAP 3'd3
`define CISE_CYC_BTST 3'd3
`define CISE_MEM_STEP 3'd1
`define CISE_ILEN16 32'h00000002
`define CISE_ILEN32 32'h00000004
`endif

// >>> logic/cise_pkg.sv
`default_nettype none
package cise_pkg;
	typedef enum logic [3:0] {
		OP_SUB = 4'b0000, OP_RSUB = 4'b0001, OP_SWITCH = 4'b0010, OP_SEXB = 4'b0011,
		OP_SEXH = 4'b0100, OP_ZEXB = 4'b0101, OP_ZEXH = 4'b0110, OP_TRAP = 4'b0111,
		OP_ANDT = 4'b1000, OP_BTSTD = 4'b1001, OP_BTSTR = 4'b1010, OP_XOR = 4'b1011,
		OP_XIMM = 4'b1100, OP_BAD = 4'b1101
	} cise_op_t;
	typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} cise_state_t;
	typedef struct packed {
		logic req;
		logic half;
		logic [31:0] addr;
	} cise_mem_req_t;
endpackage
`default_nettype wire

// >>> logic/cise_subflag.sv
`default_nettype none
module cise_subflag (
	input wire logic [31:0] minuend,
	input wire logic [31:0] subtrahend,
	output logic [31:0] diff,
	output logic borrow,
	output logic ovf
);
	logic [32:0] wide;
	assign wide = {1'b0, minuend} - {1'b0, subtrahend};
	assign diff = wide[31:0];
	assign borrow = wide[32];
	// operands of unlike sign and a result whose sign left the minuend's
	assign ovf = (minuend[31] ^ subtrahend[31]) & (minuend[31] ^ wide[31]);
endmodule // cise_subflag
`default_nettype wire

// >>> logic/cise_core.sv
`include "cise_cfg.svh"
`default_nettype none
// Overview of operation
// - subtract writes reg2 minus reg1 to reg2, sets carry, overflow, sign, zero, in one cycle.
// - reverse subtract writes reg1 minus reg2 to reg2 with the same flags, in one cycle.
// - table jump reads a halfword at pc plus two plus reg1 shifted left by one.
// - table jump then sets pc to pc plus two plus the doubled signed entry, five cycles.
// - sign extend byte or half replaces reg1 from bits 7..0 or 15..0, one cycle, no flags.
// - zero extend byte or half does likewise with zeros, one cycle, no flags.
// - a trap saves pc plus four as return address and copies the status word.
// - a trap writes the cause code and sets the in-progress and disable bits.
// - a trap jumps to 40h for vectors 0..f and to 50h for 10..1f, in three cycles.
// - and test sets sign and zero from reg1 and reg2, clears overflow, stores nothing.
// - bit test with displacement reads bit bbb at reg1 plus signed disp16 into not-zero.
// - bit test by register reads at reg1 the bit numbered by reg2 into not-zero.
// - both bit tests take three cycles plus any memory wait cycles.
// - register xor writes reg1 xor reg2 to reg2, clears overflow, sets sign and zero.
// - xor immediate writes reg1 xor zero extended imm16 to reg2 with the same flags.
module cise_core
	import cise_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output cise_mem_req_t mem_out,
	input wire logic mem_ready,
	input wire logic [15:0] mem_rdata
);
	logic ap_valid_reg;
	logic ap_wr_reg;
	logic [7:0] ap_off_reg;
	logic wr_go;
	cise_state_t state_reg;
	logic [2:0] cnt_reg;
	logic [31:0] ir_reg;
	logic [31:0] adr_reg;
	logic [15:0] mdata_reg;
	logic [31:0] gr_reg [32];
	logic [4:0] gridx_reg;
	logic [31:0] pc_reg;
	logic [31:0] pstat_reg;
	logic [31:0] retpc_reg;
	logic [31:0] savst_reg;
	logic [15:0] cause_reg;
	cise_op_t op;
	logic [4:0] r1f;
	logic [4:0] r2f;
	logic [15:0] hw1;
	logic [31:0] op1;
	logic [31:0] op2;
	logic [2:0] cyc;
	logic busy;
	logic mem_wait;
	logic done;
	logic [31:0] sub_a;
	logic [31:0] sub_b;
	logic [31:0] sub_res;
	logic sub_cy;
	logic sub_ov;
	logic [31:0] logic_res;
	logic [31:0] ext_val;
	logic bit_val;
	logic [31:0] adr_next;
	logic gr_we;
	logic [4:0] gr_wi;
	logic [31:0] gr_wd;

	// bus: address phase captured while hready, data phase acts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_reg <= 1'b0;
			ap_wr_reg <= 1'b0;
			ap_off_reg <= 8'h00;
		end else if (hready) begin
			ap_valid_reg <= hsel && htrans[1];
			ap_wr_reg <= hwrite;
			ap_off_reg <= haddr[7:0];
		end
	end

	// writes wait out a running instruction so state never has two writers
	assign busy = (state_reg == ST_EXEC);
	assign hreadyout = !(ap_valid_reg && ap_wr_reg && busy);
	assign hresp = 1'b0;
	assign wr_go = ap_valid_reg && ap_wr_reg && !busy;

	always_comb begin
		hrdata = 32'h00000000;
		if (ap_valid_reg && !ap_wr_reg) begin
			case (ap_off_reg)
			`CISE_OFF_STATUS: hrdata = {28'h0000000, cnt_reg, busy};
			`CISE_OFF_PC: hrdata = pc_reg;
			`CISE_OFF_PSTAT: hrdata = pstat_reg;
			`CISE_OFF_RETPC: hrdata = retpc_reg;
			`CISE_OFF_SAVST: hrdata = savst_reg;
			`CISE_OFF_CAUSE: hrdata = {16'h0000, cause_reg};
			`CISE_OFF_GRIDX: hrdata = {27'h0000000, gridx_reg};
			`CISE_OFF_GRDATA: hrdata = gr_reg[gridx_reg];
			`CISE_OFF_INSTR: hrdata = ir_reg;
			default: hrdata = 32'h00000000;
			endcase
		end
	end

	assign r1f = ir_reg[4:0];
	assign r2f = ir_reg[15:11];
	assign hw1 = ir_reg[31:16];
	assign op1 = gr_reg[r1f];
	assign op2 = gr_reg[r2f];

	always_comb begin
		op = OP_BAD;
		if (ir_reg[15:5] == `CISE_HI_SWITCH) begin
			op = OP_SWITCH;
		end else if (ir_reg[15:5] == `CISE_HI_SEXB) begin
			op = OP_SEXB;
		end else if (ir_reg[15:5] == `CISE_HI_SEXH) begin
			op = OP_SEXH;
		end else if (ir_reg[15:5] == `CISE_HI_ZEXB) begin
			op = OP_ZEXB;
		end else if (ir_reg[15:5] == `CISE_HI_ZEXH) begin
			op = OP_ZEXH;
		end else begin
			case (ir_reg[10:5])
			`CISE_OPC_SUB: op = OP_SUB;
			`CISE_OPC_RSUB: op = OP_RSUB;
			`CISE_OPC_ANDT: op = OP_ANDT;
			`CISE_OPC_XOR: op = OP_XOR;
			`CISE_OPC_XIMM: op = OP_XIMM;
			`CISE_OPC_BTSTD: op = (ir_reg[15:14] == `CISE_BTSTD_PRE) ? OP_BTSTD : OP_BAD;
			// the register bit test shares this field; its second halfword tells them apart
			`CISE_OPC_EXT: begin
				if (hw1 == `CISE_BTSTR_HW1)
					op = OP_BTSTR;
				else if (r2f == 5'h00)
					op = OP_TRAP;
				else
					op = OP_BAD;
			end
			default: op = OP_BAD;
			endcase
		end
	end

	always_comb begin
		case (op)
		OP_SWITCH: cyc = `CISE_CYC_SWITCH;
		OP_TRAP: cyc = `CISE_CYC_TRAP;
		OP_BTSTD, OP_BTSTR: cyc = `CISE_CYC_BTST;
		default: cyc = `CISE_CYC_ONE;
		endcase
	end

	// memory step stalls the count while the port inserts waits
	assign mem_out.req = busy && cnt_reg == `CISE_MEM_STEP &&
		(op == OP_SWITCH || op == OP_BTSTD || op == OP_BTSTR);
	assign mem_out.half = (op == OP_SWITCH);
	assign mem_out.addr = adr_reg;
	assign mem_wait = mem_out.req && !mem_ready;
	assign done = busy && !mem_wait && cnt_reg == cyc - 3'd1;

	always_comb begin
		case (op)
		OP_SWITCH: adr_next = pc_reg + `CISE_ILEN16 + {op1[30:0], 1'b0};
		OP_BTSTD: adr_next = op1 + {{16{hw1[15]}}, hw1};
		default: adr_next = op1;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 3'd0;
			ir_reg <= 32'h00000000;
			adr_reg <= 32'h00000000;
			mdata_reg <= 16'h0000;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (wr_go && ap_off_reg == `CISE_OFF_INSTR) begin
					ir_reg <= hwdata;
					cnt_reg <= 3'd0;
					state_reg <= ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (cnt_reg == 3'd0)
					adr_reg <= adr_next;
				if (mem_out.req && mem_ready)
					mdata_reg <= mem_rdata;
				if (done)
					state_reg <= ST_IDLE;
				else if (!mem_wait)
					cnt_reg <= cnt_reg + 3'd1;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	cise_subflag u_sub (
		.minuend(sub_a),
		.subtrahend(sub_b),
		.diff(sub_res),
		.borrow(sub_cy),
		.ovf(sub_ov)
	);
	assign sub_a = (op == OP_RSUB) ? op1 : op2;
	assign sub_b = (op == OP_RSUB) ? op2 : op1;

	always_comb begin
		case (op)
		OP_ANDT: logic_res = op1 & op2;
		OP_XIMM: logic_res = op1 ^ {16'h0000, hw1};
		default: logic_res = op1 ^ op2;
		endcase
	end

	always_comb begin
		case (op)
		OP_SEXB: ext_val = {{24{op1[7]}}, op1[7:0]};
		OP_SEXH: ext_val = {{16{op1[15]}}, op1[15:0]};
		OP_ZEXB: ext_val = {24'h000000, op1[7:0]};
		default: ext_val = {16'h0000, op1[15:0]};
		endcase
	end

	// memory byte arrives on the low lane
	assign bit_val = (op == OP_BTSTD) ? mdata_reg[ir_reg[13:11]] : mdata_reg[op2[2:0]];

	always_comb begin
		gr_we = 1'b0;
		gr_wi = r2f;
		gr_wd = logic_res;
		if (done) begin
			case (op)
			OP_SUB, OP_RSUB: begin
				gr_we = 1'b1;
				gr_wd = sub_res;
			end
			OP_XOR, OP_XIMM: gr_we = 1'b1;
			OP_SEXB, OP_SEXH, OP_ZEXB, OP_ZEXH: begin
				gr_we = 1'b1;
				gr_wi = r1f;
				gr_wd = ext_val;
			end
			default: gr_we = 1'b0;
			endcase
		end else if (wr_go && ap_off_reg == `CISE_OFF_GRDATA) begin
			gr_we = 1'b1;
			gr_wi = gridx_reg;
			gr_wd = hwdata;
		end
	end

	// entry zero is wired to zero, so writes to it are dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 32; i++)
				gr_reg[i] <= 32'h00000000;
		end else if (gr_we && gr_wi != 5'h00) begin
			gr_reg[gr_wi] <= gr_wd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			gridx_reg <= 5'h00;
		else if (wr_go && ap_off_reg == `CISE_OFF_GRIDX)
			gridx_reg <= hwdata[4:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_reg <= `CISE_PC_RST;
			pstat_reg <= `CISE_PSTAT_RST;
			retpc_reg <= 32'h00000000;
			savst_reg <= 32'h00000000;
			cause_reg <= 16'h0000;
		end else if (done) begin
			pc_reg <= pc_reg + `CISE_ILEN16;
			case (op)
			OP_SUB, OP_RSUB: begin
				pstat_reg[`CISE_FLG_CARRY] <= sub_cy;
				pstat_reg[`CISE_FLG_OVF] <= sub_ov;
				pstat_reg[`CISE_FLG_S] <= sub_res[31];
				pstat_reg[`CISE_FLG_Z] <= (sub_res == 32'h00000000);
			end
			OP_ANDT, OP_XOR, OP_XIMM: begin
				pstat_reg[`CISE_FLG_OVF] <= 1'b0;
				pstat_reg[`CISE_FLG_S] <= logic_res[31];
				pstat_reg[`CISE_FLG_Z] <= (logic_res == 32'h00000000);
				if (op == OP_XIMM)
					pc_reg <= pc_reg + `CISE_ILEN32;
			end
			OP_SWITCH: pc_reg <= pc_reg + `CISE_ILEN16 +
				{{15{mdata_reg[15]}}, mdata_reg, 1'b0};
			OP_BTSTD, OP_BTSTR: begin
				pstat_reg[`CISE_FLG_Z] <= !bit_val;
				pc_reg <= pc_reg + `CISE_ILEN32;
			end
			OP_TRAP: begin
				retpc_reg <= pc_reg + `CISE_ILEN32;
				savst_reg <= pstat_reg;
				cause_reg <= `CISE_TRAP_CODE + {11'h000, r1f};
				pstat_reg[`CISE_FLG_EXC] <= 1'b1;
				pstat_reg[`CISE_FLG_IDIS] <= 1'b1;
				pc_reg <= r1f[4] ? `CISE_TRAP_PC_HI : `CISE_TRAP_PC_LO;
			end
			default: pstat_reg <= pstat_reg;
			endcase
		end else if (wr_go && ap_off_reg == `CISE_OFF_PC) begin
			pc_reg <= hwdata;
		end else if (wr_go && ap_off_reg == `CISE_OFF_PSTAT) begin
			pstat_reg <= hwdata;
		end
	end

	// helper counters that only the checks below read
	logic [7:0] len_ct;
	logic [7:0] wt_ct;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			len_ct <= 8'h00;
			wt_ct <= 8'h00;
		end else if (!busy) begin
			len_ct <= 8'h00;
			wt_ct <= 8'h00;
		end else begin
			len_ct <= len_ct + 8'h01;
			if (mem_wait)
				wt_ct <= wt_ct + 8'h01;
		end
	end
	logic launch;
	assign launch = !busy && wr_go && ap_off_reg == `CISE_OFF_INSTR;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_done(cise_op_t o);
		done && op == o;
	endsequence
	sequence s_dest;
		r2f != 5'h00;
	endsequence

	property p_sub;
		s_done(OP_SUB) and s_dest |=> gr_reg[$past(r2f)] == $past(op2) - $past(op1);
	endproperty
	a_sub: assert property (p_sub) else $error("subtract result wrong");
	property p_rsub_carry;
		s_done(OP_RSUB) |=> pstat_reg[`CISE_FLG_CARRY] == ($past(op1) < $past(op2));
	endproperty
	a_rsub_carry: assert property (p_rsub_carry) else $error("reverse subtract carry wrong");
	property p_one_cycle;
		launch |=> busy ##1 (cyc != `CISE_CYC_ONE || !busy);
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("single cycle op overran");
	property p_sw_adr;
		mem_out.req && op == OP_SWITCH |-> mem_out.addr == pc_reg + 32'h2 + {op1[30:0], 1'b0};
	endproperty
	a_sw_adr: assert property (p_sw_adr) else $error("table address wrong");
	property p_sw_len;
		s_done(OP_SWITCH) |-> len_ct + 8'h01 == 8'h05 + wt_ct;
	endproperty
	a_sw_len: assert property (p_sw_len) else $error("table jump length wrong");
	property p_sw_pc;
		s_done(OP_SWITCH) |=> pc_reg == $past(pc_reg) + 32'h2 +
			{{15{$past(mdata_reg[15])}}, $past(mdata_reg), 1'b0};
	endproperty
	a_sw_pc: assert property (p_sw_pc) else $error("table jump target wrong");
	property p_ext;
		done && (op == OP_SEXB || op == OP_ZEXH) && r1f != 5'h00 |=>
			gr_reg[$past(r1f)] == $past(ext_val) && $stable(pstat_reg);
	endproperty
	a_ext: assert property (p_ext) else $error("extension wrong");
	property p_trap;
		s_done(OP_TRAP) |=> retpc_reg == $past(pc_reg) + 32'h4 && savst_reg == $past(pstat_reg)
			&& pstat_reg[`CISE_FLG_EXC] && pstat_reg[`CISE_FLG_IDIS];
	endproperty
	a_trap: assert property (p_trap) else $error("trap save wrong");
	property p_trap_len;
		launch ##1 op == OP_TRAP |-> busy [*3] ##1 !busy ##0 pc_reg ==
			($past(r1f[4]) ? 32'h50 : 32'h40);
	endproperty
	a_trap_len: assert property (p_trap_len) else $error("trap timing or vector wrong");
	property p_andt;
		s_done(OP_ANDT) |=> !pstat_reg[`CISE_FLG_OVF] && pstat_reg[`CISE_FLG_Z] ==
			(($past(op1) & $past(op2)) == 32'h0) && gr_reg[$past(r2f)] == $past(op2);
	endproperty
	a_andt: assert property (p_andt) else $error("and test wrong");
	property p_btst;
		done && (op == OP_BTSTD || op == OP_BTSTR) |-> len_ct + 8'h01 == 8'h03 + wt_ct
			##1 pstat_reg[`CISE_FLG_Z] == !$past(bit_val);
	endproperty
	a_btst: assert property (p_btst) else $error("bit test wrong");
	property p_xor;
		s_done(OP_XOR) and s_dest |=> gr_reg[$past(r2f)] == ($past(op1) ^ $past(op2))
			&& !pstat_reg[`CISE_FLG_OVF];
	endproperty
	a_xor: assert property (p_xor) else $error("xor wrong");
	property p_ximm;
		s_done(OP_XIMM) and s_dest |=> gr_reg[$past(r2f)] == ($past(op1) ^ {16'h0, $past(hw1)});
	endproperty
	a_ximm: assert property (p_ximm) else $error("xor immediate wrong");
endmodule // cise_core
`default_nettype wire

// >>> verif/cise_mem_model.sv
`default_nettype none
module cise_mem_model
	import cise_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire cise_mem_req_t mem_in,
	input wire logic [3:0] waits,
	output logic mem_ready,
	output logic [15:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_reg;
	logic [15:0] last_reg;
	// each halfword carries its own low address byte, so a wrong low address byte shows in the data
	assign mem_ready = mem_in.req && (cnt_reg == waits);
	// outside a read the lines flip, so stale data is never mistaken for an answer
	assign mem_rdata = mem_ready ? {~mem_in.addr[7:0], mem_in.addr[7:0]} : ~last_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 4'h0;
			last_reg <= 16'h0000;
		end else if (mem_ready) begin
			cnt_reg <= 4'h0;
			last_reg <= mem_rdata;
		end else if (mem_in.req) begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule // cise_mem_model
`default_nettype wire

// >>> verif/cise_core_tb.sv
`include "cise_cfg.svh"
`default_nettype none
module cise_core_tb
	import cise_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mem_ready, cap_half;
	logic [31:0] haddr, hwdata, hrdata, cap_addr, g, a, b, res, adr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] mem_rdata, ent;
	logic [3:0] waits;
	logic [5:0] opc[5];
	logic [10:0] ext_hi[4];
	logic [31:0] ext_exp[4], opa[3], opb[3];
	logic carry, ovf, st, z;
	cise_mem_req_t mem_out;
	int n_fail, checks, nw, bt[4], wt[4];
	assign hready = hreadyout;
	cise_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .mem_out(mem_out), .mem_ready(mem_ready),
		.mem_rdata(mem_rdata));
	cise_mem_model mem (.hclk(hclk), .hresetn(hresetn), .mem_in(mem_out), .waits(waits),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(negedge hclk) begin
		if (mem_out.req === 1'b1 && mem_ready === 1'b1) begin
			cap_addr = mem_out.addr;
			cap_half = mem_out.half;
		end
	end
	task automatic results;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// nw counts stalled data-phase cycles; sampling at the falling edge keeps it race free
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rdv, output int nws);
		logic r;
		nws = -1;
		haddr <= {24'h000000, ad};
		hwrite <= w;
		htrans <= 2'h2;
		do begin
			@(negedge hclk);
			r = hreadyout;
			@(posedge hclk);
		end while (r !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(negedge hclk);
			r = hreadyout;
			rdv = hrdata;
			nws++;
			@(posedge hclk);
		end while (r !== 1'b1);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] x;
		int n;
		xfer(1'b1, ad, d, x, n);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		int n;
		xfer(1'b0, ad, 32'h00000000, d, n);
	endtask
	task automatic set_gr(input logic [4:0] i, input logic [31:0] v);
		wr(`CISE_OFF_GRIDX, {27'h0, i});
		wr(`CISE_OFF_GRDATA, v);
	endtask
	task automatic get_gr(input logic [4:0] i, output logic [31:0] v);
		wr(`CISE_OFF_GRIDX, {27'h0, i});
		rd(`CISE_OFF_GRDATA, v);
	endtask
	// a write right behind the instruction stalls for all but the first busy cycle
	task automatic exec(input logic [31:0] instr, output int n);
		logic [31:0] x;
		wr(`CISE_OFF_INSTR, instr);
		xfer(1'b1, `CISE_OFF_GRIDX, 32'h00000000, x, n);
	endtask
	initial begin
		#400000;
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		results;
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		waits = 4'h0;
		n_fail = 0;
		checks = 0;
		cap_addr = 32'h0;
		cap_half = 1'b0;
		opc = '{`CISE_OPC_SUB, `CISE_OPC_RSUB, `CISE_OPC_ANDT, `CISE_OPC_XOR, `CISE_OPC_XIMM};
		ext_hi = '{`CISE_HI_SEXB, `CISE_HI_SEXH, `CISE_HI_ZEXB, `CISE_HI_ZEXH};
		ext_exp = '{32'hffffff80, 32'hffff8680, 32'h00000080, 32'h00008680};
		opa = '{32'h00000005, 32'h00000001, 32'h0000ffff};
		opb = '{32'h00000003, 32'h80000000, 32'h0000ffff};
		bt = '{2, 3, 1, 4};
		wt = '{0, 2, 1, 3};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		hsel <= 1'b1;
		rd(`CISE_OFF_PSTAT, g);
		chk(g, 32'h0, "status reset");
		rd(`CISE_OFF_STATUS, g);
		chk(g, 32'h0, "idle status");
		wr(8'h24, 32'hffffffff);
		rd(8'h24, g);
		chk(g, 32'h0, "unmapped");
		chk({31'h0, hresp}, 32'h0, "okay response");
		for (int k = 0; k < 5; k++) begin
			for (int j = 0; j < 3; j++) begin
				a = opa[j];
				b = opb[j];
				set_gr(5'h03, a);
				set_gr(5'h11, b);
				wr(`CISE_OFF_PSTAT, 32'h0000000c);
				exec({16'h8421, 5'h11, opc[k], 5'h03}, nw);
				st = (k != 2);
				carry = 1'b1;
				ovf = 1'b0;
				case (k)
					0: res = b - a;
					1: res = a - b;
					2: res = a & b;
					3: res = a ^ b;
					default: res = a ^ 32'h00008421;
				endcase
				if (k == 0) begin
					carry = b < a;
					ovf = (a[31] != b[31]) && (res[31] != b[31]);
				end else if (k == 1) begin
					carry = a < b;
					ovf = (a[31] != b[31]) && (res[31] != a[31]);
				end
				get_gr(5'h11, g);
				chk(g, st ? res : b, "dest reg");
				get_gr(5'h03, g);
				chk(g, a, "source reg");
				rd(`CISE_OFF_PSTAT, g);
				chk(g, {28'h0, carry, ovf, res[31], res == 32'h0}, "flags");
				chk(32'(nw), 32'h0, "one cycle");
			end
		end
		for (int i = 0; i < 4; i++) begin
			set_gr(5'h09, 32'h12348680);
			wr(`CISE_OFF_PSTAT, 32'h0000000f);
			exec({16'h0000, ext_hi[i], 5'h09}, nw);
			get_gr(5'h09, g);
			chk(g, ext_exp[i], "extend");
			rd(`CISE_OFF_PSTAT, g);
			chk(g, 32'h0000000f, "extend flags");
			chk(32'(nw), 32'h0, "extend cycle");
		end
		set_gr(5'h04, 32'h00000008);
		wr(`CISE_OFF_PC, 32'h00000100);
		wr(`CISE_OFF_PSTAT, 32'h00000000);
		exec({16'h0000, `CISE_HI_SWITCH, 5'h04}, nw);
		adr = 32'h00000102 + (32'h00000008 << 1);
		ent = {~adr[7:0], adr[7:0]};
		chk(cap_addr, adr, "table addr");
		chk({31'h0, cap_half}, 32'h1, "table half");
		rd(`CISE_OFF_PC, g);
		chk(g, 32'h00000102 + ({{16{ent[15]}}, ent} << 1), "table pc");
		rd(`CISE_OFF_PSTAT, g);
		chk(g, 32'h0, "table flags");
		chk(32'(nw), 32'h4, "table cycles");
		for (int v = 15; v < 17; v++) begin
			wr(`CISE_OFF_PC, 32'h00000200);
			wr(`CISE_OFF_PSTAT, 32'h0000000f);
			exec({16'h0100, 5'h00, 6'h3f, 5'(v)}, nw);
			rd(`CISE_OFF_RETPC, g);
			chk(g, 32'h00000204, "return pc");
			rd(`CISE_OFF_SAVST, g);
			chk(g, 32'h0000000f, "saved status");
			rd(`CISE_OFF_CAUSE, g);
			chk(g, 32'h00000040 + 32'(v), "cause");
			rd(`CISE_OFF_PSTAT, g);
			chk(g, 32'h0000006f, "trap status");
			rd(`CISE_OFF_PC, g);
			chk(g, (v < 16) ? 32'h00000040 : 32'h00000050, "vector");
			chk(32'(nw), 32'h2, "trap cycles");
		end
		for (int i = 0; i < 4; i++) begin
			waits <= 4'(wt[i]);
			set_gr(5'h06, 32'h00000355);
			set_gr(5'h11, 32'(bt[i]));
			adr = (i < 2) ? 32'h00000345 : 32'h00000355;
			z = ~adr[bt[i]];
			wr(`CISE_OFF_PSTAT, {28'h0, 3'h7, ~z});
			if (i < 2)
				exec({16'hfff0, 2'h3, 3'(bt[i]), 6'h3e, 5'h06}, nw);
			else
				exec({16'h00e6, 5'h11, 6'h3f, 5'h06}, nw);
			chk(cap_addr, adr, "bit addr");
			chk({31'h0, cap_half}, 32'h0, "bit byte");
			rd(`CISE_OFF_PSTAT, g);
			chk(g, {28'h0, 3'h7, z}, "bit flag");
			chk(32'(nw), 32'(2 + wt[i]), "bit cycles");
		end
		results;
	end
endmodule // cise_core_tb
`default_nettype wire
